// ### ppm_consts.svh
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH
// ==========================================
// apb register offsets (byte addresses)
`define PPM_OFF_CFG        12'h000
`define PPM_OFF_STAT       12'h004
`define PPM_OFF_EE_ADDR    12'h008
`define PPM_OFF_EE_DATA    12'h00c
`define PPM_OFF_ID_FIRST   12'h020
`define PPM_OFF_ID_LAST    12'h03c
// ==========================================
// config_word_four_low field positions
`define PPM_BIT_RD_GUARD   0
`define PPM_BIT_WR_GUARD   1
`define PPM_BIT_CFG_GUARD  2
`define PPM_BIT_DEBUG_N    3
`define PPM_BIT_LVP        4
`define PPM_CFG_ERASED     8'h1f
`define PPM_CFG_CPU_LOCK   8'h14
`define PPM_CFG_LVP_MASK   8'h10
// ==========================================
// programming-port address map
`define PPM_ID_BASE        22'h200000
`define PPM_CFG_ADDR       22'h300000
`define PPM_EE_BASE        22'h3f0000
// ==========================================
// debugger reservations
`define PPM_DBG_PINS       2'h3
`define PPM_DBG_STACK      5'h02
`define PPM_DBG_PROG_BYTES 10'h200
`define PPM_DBG_DATA_BYTES 4'ha
`endif

// ### ppm_guard.sv
// Behaviour
// (R1) data_mem_read_guard active blocks external data EEPROM reads and writes.
// (R2) data_mem_write_guard active blocks external data EEPROM writes only.
// (R3) cpu data EEPROM reads and writes ignore the guard bits.
// (R4) config_write_guard active blocks writes to the configuration word.
// (R5) cpu cannot change config_write_guard; only the programming port can.
// (R6) eight ID bytes at 200000h-200007h, reachable by cpu and programming port.
// (R7) ID bytes stay readable whatever the protection bits say.
// (R8) debugger enabled only while the debug bit is 0.
// (R9) enabled debugger reserves two pins, 2 stack levels, 512 and 10 bytes.
// (R10) low_volt_prog_en allows entry without the elevated voltage.
// (R11) with low_volt_prog_en set, prog_entry_pin serves only entry detection.
// (R12) programmer drives prog_entry_pin high; honoured only with low_volt_prog_en set.
// (R13) low_volt_prog_en erased value is 1.
// (R14) elevated-voltage entry always accepted, whatever low_volt_prog_en says.
// (R15) with low_volt_prog_en clear, prog_entry_pin is ordinary I/O.
// (R16) low_volt_prog_en changes only in a high-voltage programming session (rst_n here also sets it back to 1 outside a session).
// (R17) low_volt_prog_en clear: low-voltage entry ignored, only high-voltage entry.
// (R18) with low_volt_prog_en set, the pin pull-up is disabled.
// (R19) software clears output latch bit 5 if the entry pin is an output.
// (R20) system should hold prog_entry_pin low in normal operation.
// (R21) protection bits go 1 to 0 by writes; only bulk erase restores 1 (rst_n here also reloads the erased word).
// (R22) each access carries its origin; guards gate external-origin accesses only (config_write_guard here also blocks cpu writes).
`timescale 1ns/1ps
`include "ppm_consts.svh"
module ppm_guard
  import ppm_pkg::*;
#(
  parameter int EE_DEPTH = 256,
  parameter int ID_COUNT = 8
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // raw pins
  input  wire logic        prog_entry_pin,
  input  wire logic        elevated_entry_voltage,
  // programming-port requests from the serial link decoder
  input  wire logic        ext_valid,
  input  ppm_req_type      ext_req,
  output logic             ext_ready,
  output logic             ext_done,
  output logic             ext_denied,
  output logic      [7:0]  ext_rdata,
  // mode and pin control
  output logic             prog_mode,
  output logic             prog_hv_session,
  output logic             prog_pin_dedicated,
  output logic             prog_pin_pullup_off,
  output logic             debug_enable,
  output logic      [1:0]  debug_pin_reserve,
  output logic      [4:0]  debug_stack_levels,
  output logic      [9:0]  debug_prog_bytes,
  output logic      [3:0]  debug_data_bytes
);

  localparam int EE_AW = (EE_DEPTH > 1) ? $clog2(EE_DEPTH) : 1;
  // port address masks; the eeprom window follows the depth, so a smaller store leaves the rest of the window unmapped
  localparam logic [21:0] EE_MASK = 22'(EE_DEPTH - 1);
  localparam logic [21:0] ID_MASK = 22'h000007;

  // ==========================================
  // elaboration checks
  generate
    if (EE_DEPTH < 2 || EE_DEPTH > 256 || (EE_DEPTH & (EE_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("EE_DEPTH must be a power of two from 2 to 256");
    end
    if (ID_COUNT != 8) begin : g_bad_id
      $error("ID_COUNT must be 8");
    end
    if ((`PPM_OFF_ID_LAST - `PPM_OFF_ID_FIRST) / 4 + 1 != ID_COUNT) begin : g_bad_window
      $error("ID window must hold one word per ID byte");
    end
  endgenerate

  // ==========================================
  // shared decisions
  // one place decides protection for every access so both paths agree
  // guard bits are open at 1 and guarding at 0, so an erased word leaves all paths open
  function automatic logic access_allowed(ppm_origin_type origin, ppm_space_type space,
                                          logic wr, logic [7:0] cfg_bits);
    logic ok;
    ok = 1'b0;
    unique case (space)
      PPM_SPACE_EE:   ok = (origin == PPM_ORIGIN_CPU) ||                         // R3 R22
                           (cfg_bits[`PPM_BIT_RD_GUARD] &&                         // R1
                            (!wr || cfg_bits[`PPM_BIT_WR_GUARD]));                 // R2
      PPM_SPACE_CFG:  ok = !wr || cfg_bits[`PPM_BIT_CFG_GUARD];                    // R4
      PPM_SPACE_ID:   ok = 1'b1;                                                   // R7
      PPM_SPACE_NONE: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ==========================================
  // state
  // ee_addr is the cpu's pointer into the store; the port addresses the store directly
  logic [7:0]       cfg;
  ppm_mode_type     mode;
  logic [1:0]       pin_sync;
  logic [1:0]       hv_sync;
  logic [7:0]       ee_mem [EE_DEPTH];
  logic [7:0]       id_mem [ID_COUNT];
  logic [EE_AW-1:0] ee_addr;

  // ==========================================
  // pin synchronisers; only bit 1 is read by logic
  // two cycles of entry latency are traded for immunity to a metastable pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_sync <= 2'h0;
      hv_sync  <= 2'h0;
    end else begin
      pin_sync <= {pin_sync[0], prog_entry_pin};
      hv_sync  <= {hv_sync[0], elevated_entry_voltage};
    end
  end

  wire logic low_volt_prog_en = cfg[`PPM_BIT_LVP];

  // ==========================================
  // programming entry and exit
  // a session lasts as long as its entry condition holds; hv overrides lv
  // a pin pulse shorter than a clock can be missed; entry wants a standing level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode <= PPM_RUN;
    end else begin
      unique case (mode)
        PPM_RUN: begin
          if (hv_sync[1]) begin
            mode <= PPM_PROG_HV;                                                   // R14
          end else if (pin_sync[1] && low_volt_prog_en) begin
            mode <= PPM_PROG_LV;                                                   // R10 R12 R17
          end
        end
        PPM_PROG_HV: begin
          if (!hv_sync[1]) begin
            mode <= PPM_RUN;
          end
        end
        PPM_PROG_LV: begin
          if (hv_sync[1]) begin
            mode <= PPM_PROG_HV;
          end else if (!pin_sync[1]) begin
            mode <= PPM_RUN;
          end
        end
        default: begin
          // an unused code falls back to run, never into a session
          mode <= PPM_RUN;
        end
      endcase
    end
  end

  // session kinds, named once for the status word and the lock on the lvp bit
  logic in_hv;
  logic in_lv;

  assign in_hv = (mode == PPM_PROG_HV);
  assign in_lv = (mode == PPM_PROG_LV);

  // ==========================================
  // programming-port decode
  ppm_space_type ext_space;
  logic          ext_take;
  logic          ext_wr;
  logic          ext_erase;
  logic          ext_ok;

  always_comb begin
    ext_space = PPM_SPACE_NONE;
    if ((ext_req.addr & ~ID_MASK) == `PPM_ID_BASE) begin
      ext_space = PPM_SPACE_ID;                                                    // R6
    end else if (ext_req.addr == `PPM_CFG_ADDR) begin
      ext_space = PPM_SPACE_CFG;
    end else if ((ext_req.addr & ~EE_MASK) == `PPM_EE_BASE) begin
      ext_space = PPM_SPACE_EE;
    end
  end

  // requests are refused outside a programming session
  // the origin field is trusted: the link decoder alone marks what arrives as external
  assign ext_ready = (mode != PPM_RUN);
  assign ext_take  = ext_valid && ext_ready;
  assign ext_wr    = (ext_req.cmd == PPM_CMD_WRITE);
  assign ext_erase = (ext_req.cmd == PPM_CMD_BULK_ERASE);
  assign ext_ok    = ext_erase || access_allowed(ext_req.origin, ext_space, ext_wr, cfg);

  // ==========================================
  // apb decode
  // unmapped offsets answer with pslverr; a status write is ignored without error
  ppm_space_type apb_space;
  logic          apb_take;
  logic          apb_mapped;
  logic          apb_ok;
  logic [2:0]    apb_id_idx;

  assign apb_take   = psel && penable && !pready;
  assign apb_id_idx = paddr[4:2];

  always_comb begin
    apb_space  = PPM_SPACE_NONE;
    apb_mapped = 1'b1;
    if (paddr == `PPM_OFF_CFG) begin
      apb_space = PPM_SPACE_CFG;
    end else if (paddr == `PPM_OFF_EE_DATA) begin
      apb_space = PPM_SPACE_EE;
    end else if (paddr >= `PPM_OFF_ID_FIRST && paddr <= `PPM_OFF_ID_LAST && paddr[1:0] == 2'h0) begin
      apb_space = PPM_SPACE_ID;                                                    // R6
    end else if (paddr != `PPM_OFF_STAT && paddr != `PPM_OFF_EE_ADDR) begin
      apb_mapped = 1'b0;
    end
  end

  // cpu side accesses are always tagged as cpu origin
  assign apb_ok = apb_mapped &&
                  (apb_space == PPM_SPACE_NONE ||
                   access_allowed(PPM_ORIGIN_CPU, apb_space, pwrite, cfg));        // R22

  // ==========================================
  // write strobes
  // one named strobe per store keeps the priority between the two paths in one place
  logic ext_wr_cfg;
  logic ext_wr_ee;
  logic ext_wr_id;
  logic apb_wr_cfg;
  logic apb_wr_ee;
  logic apb_wr_id;
  logic apb_wr_ptr;

  assign ext_wr_cfg = ext_take && ext_wr && ext_space == PPM_SPACE_CFG && ext_ok;      // R4
  assign ext_wr_ee  = ext_take && ext_wr && ext_space == PPM_SPACE_EE && ext_ok;       // R1 R2
  assign ext_wr_id  = ext_take && ext_wr && ext_space == PPM_SPACE_ID;                 // R6
  assign apb_wr_cfg = apb_take && pwrite && apb_space == PPM_SPACE_CFG && apb_ok;      // R4
  assign apb_wr_ee  = apb_take && pwrite && apb_space == PPM_SPACE_EE;                 // R3
  assign apb_wr_id  = apb_take && pwrite && apb_space == PPM_SPACE_ID;                 // R6
  assign apb_wr_ptr = apb_take && pwrite && paddr == `PPM_OFF_EE_ADDR;

  // ==========================================
  // configuration word
  // ext path wins a same-cycle clash; in a session the cpu is normally held anyway
  // a cleared guard cannot be reopened by any write, only by a bulk erase or a reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg <= `PPM_CFG_ERASED;                                                      // R13
    end else if (ext_take && ext_erase) begin
      cfg <= `PPM_CFG_ERASED;                                                      // R21
    end else if (ext_wr_cfg) begin
      // bits only fall; lvp held unless the current session is a high-voltage one (in_hv)
      cfg <= cfg & (ext_req.wdata |
                    (in_hv ? 8'h00 : `PPM_CFG_LVP_MASK));                          // R16 R21
    end else if (apb_wr_cfg) begin
      // the cpu may close guards but never touch the cfg guard or lvp
      cfg <= cfg & (pwdata[7:0] | `PPM_CFG_CPU_LOCK);                              // R5 R16 R21
    end
  end

  // ==========================================
  // data EEPROM storage
  // arrays carry no reset: contents model nonvolatile cells
  // a cpu write that meets a port write in one cycle is lost; the port owns a session
  always_ff @(posedge clk) begin
    if (ext_wr_ee) begin
      ee_mem[ext_req.addr[EE_AW-1:0]] <= ext_req.wdata;                            // R1 R2
    end else if (apb_wr_ee) begin
      ee_mem[ee_addr] <= pwdata[7:0];                                              // R3
    end
  end

  // ==========================================
  // ID storage
  // never guarded: the bytes hold checksums that a tool must read back at any time
  always_ff @(posedge clk) begin
    if (ext_wr_id) begin
      id_mem[ext_req.addr[2:0]] <= ext_req.wdata;                                  // R6
    end else if (apb_wr_id) begin
      id_mem[apb_id_idx] <= pwdata[7:0];                                           // R6
    end
  end

  // cpu eeprom pointer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ee_addr <= '0;
    end else if (apb_wr_ptr) begin
      ee_addr <= pwdata[EE_AW-1:0];
    end
  end

  // ==========================================
  // programming-port answer, one cycle after the take
  // read data is zero for writes and refusals, so a denied read leaks nothing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_done   <= 1'b0;
      ext_denied <= 1'b0;
      ext_rdata  <= 8'h00;
    end else begin
      ext_done   <= ext_take;
      ext_denied <= ext_take && !ext_ok;
      if (ext_take) begin
        ext_rdata <= 8'h00;
        if (ext_ok && ext_req.cmd == PPM_CMD_READ) begin
          unique case (ext_space)
            PPM_SPACE_EE:   ext_rdata <= ee_mem[ext_req.addr[EE_AW-1:0]];          // R1
            PPM_SPACE_CFG:  ext_rdata <= cfg;
            PPM_SPACE_ID:   ext_rdata <= id_mem[ext_req.addr[2:0]];                // R7
            PPM_SPACE_NONE: ext_rdata <= 8'h00;
          endcase
        end
      end
    end
  end

  // ==========================================
  // apb answer: one wait state, so read data comes from a flop
  // writes land at the take edge, the same edge that raises pready; no later read can miss them
  logic [31:0] next_prdata;
  logic [4:0]  stat_bits;

  // status fields, lowest first: session, hv, lv, debugger, pin dedicated
  assign stat_bits = {prog_pin_dedicated, debug_enable, in_lv, in_hv, prog_mode};

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (paddr == `PPM_OFF_CFG) begin
      next_prdata = {24'h00_0000, cfg};
    end else if (paddr == `PPM_OFF_STAT) begin
      next_prdata = {27'h000_0000, stat_bits};
    end else if (paddr == `PPM_OFF_EE_ADDR) begin
      next_prdata[EE_AW-1:0] = ee_addr;
    end else if (apb_space == PPM_SPACE_EE) begin
      next_prdata = {24'h00_0000, ee_mem[ee_addr]};                                // R3
    end else if (apb_space == PPM_SPACE_ID) begin
      next_prdata = {24'h00_0000, id_mem[apb_id_idx]};                             // R7
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_take;
      pslverr <= apb_take && !apb_ok;                                              // R4
      if (apb_take && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // ==========================================
  // pin ownership and debugger resources
  // the figures only announce what the core must set aside; nothing here enforces them
  assign prog_mode           = (mode != PPM_RUN);
  assign prog_hv_session     = (mode == PPM_PROG_HV);
  assign prog_pin_dedicated  = low_volt_prog_en;                                                // R11 R15
  assign prog_pin_pullup_off = low_volt_prog_en;                                                // R18
  assign debug_enable        = !cfg[`PPM_BIT_DEBUG_N];                             // R8
  assign debug_pin_reserve   = debug_enable ? `PPM_DBG_PINS : 2'h0;                // R9
  assign debug_stack_levels  = debug_enable ? `PPM_DBG_STACK : 5'h00;              // R9
  assign debug_prog_bytes    = debug_enable ? `PPM_DBG_PROG_BYTES : 10'h000;       // R9
  assign debug_data_bytes    = debug_enable ? `PPM_DBG_DATA_BYTES : 4'h0;          // R9

endmodule

// ### ppm_guard_chk.sv
`timescale 1ns/1ps
// ==========================================
// port-level checks of the guard block
module ppm_guard_chk
  import ppm_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_valid,
  input wire ppm_req_type ext_req,
  input wire logic        ext_ready,
  input wire logic        ext_done,
  input wire logic        ext_denied,
  input wire logic        prog_mode,
  input wire logic        prog_hv_session,
  input wire logic        prog_pin_dedicated,
  input wire logic        prog_pin_pullup_off,
  input wire logic        debug_enable,
  input wire logic  [1:0] debug_pin_reserve,
  input wire logic  [4:0] debug_stack_levels,
  input wire logic  [9:0] debug_prog_bytes,
  input wire logic  [3:0] debug_data_bytes
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // bus answers come one cycle after the take and never stretch
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer missing");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // programming port answers, tied to their take
  ext_answer_a: assert property (ext_valid && ext_ready |=> ext_done)
    else $error("ext request unanswered");
  done_cause_a: assert property (ext_done |-> $past(ext_valid && ext_ready))
    else $error("ext done without take");
  denied_done_a: assert property (ext_denied |-> ext_done)
    else $error("ext denied without done");
  id_open_a: assert property (ext_valid && ext_ready && ext_req.addr[21:3] == 19'h40000 |=> !ext_denied)
    else $error("id access refused");
  erase_back_a: assert property (ext_valid && ext_ready && ext_req.cmd == PPM_CMD_BULK_ERASE |=> prog_pin_dedicated)
    else $error("erase left bits clear");
  // debugger reservations follow the enable exactly
  debug_res_a: assert property (debug_enable |-> {debug_pin_reserve, debug_stack_levels,
    debug_prog_bytes, debug_data_bytes} == {2'h3, 5'h02, 10'h200, 4'ha}) else $error("debug reservation wrong");
  debug_idle_a: assert property (!debug_enable |-> {debug_pin_reserve, debug_stack_levels,
    debug_prog_bytes, debug_data_bytes} == 21'h0) else $error("reservation while debug off");
  pin_dedicate_a: assert property (prog_pin_pullup_off == prog_pin_dedicated)
    else $error("pull-up not tied to dedication");
  session_a: assert property (ext_ready == prog_mode)
    else $error("ext ready outside session");
  lv_pullup_a: assert property (prog_mode && !prog_hv_session |-> prog_pin_pullup_off && prog_pin_dedicated)
    else $error("low-voltage session with pull-up on");
endmodule
bind ppm_guard ppm_guard_chk ppm_guard_chk_i (.clk, .rst_n, .psel, .penable, .pready, .pslverr, .ext_valid,
  .ext_req, .ext_ready, .ext_done, .ext_denied, .prog_mode, .prog_pin_dedicated, .prog_pin_pullup_off,
  .prog_hv_session, .debug_enable, .debug_pin_reserve, .debug_stack_levels, .debug_prog_bytes, .debug_data_bytes);

// ### ppm_pkg.sv
package ppm_pkg;
  typedef enum logic {PPM_ORIGIN_CPU, PPM_ORIGIN_EXT} ppm_origin_type;
  typedef enum logic [1:0] {PPM_CMD_READ, PPM_CMD_WRITE, PPM_CMD_BULK_ERASE} ppm_cmd_type;
  typedef enum logic [1:0] {PPM_SPACE_NONE, PPM_SPACE_EE, PPM_SPACE_CFG, PPM_SPACE_ID} ppm_space_type;
  typedef enum logic [1:0] {PPM_RUN, PPM_PROG_HV, PPM_PROG_LV} ppm_mode_type;
  typedef struct packed {
    ppm_origin_type origin;
    ppm_cmd_type    cmd;
    logic [21:0]    addr;
    logic [7:0]     wdata;
  } ppm_req_type;
endpackage

// ### ppm_prog_model.sv
`timescale 1ns/1ps
// ==========================================
// programmer on the far side of the link
module ppm_prog_model
  import ppm_pkg::*;
(
  input  wire logic       clk,
  output logic            prog_entry_pin,
  output logic            elevated_entry_voltage,
  output logic            ext_valid,
  output ppm_req_type     ext_req,
  input  wire logic       ext_ready,
  input  wire logic       ext_done,
  input  wire logic       ext_denied,
  input  wire logic [7:0] ext_rdata
);
  // entry pin rests low so no session starts by accident
  // software never drives it here; an output with its latch bit cleared shows the same low
  initial begin
    prog_entry_pin = 1'h0;
    elevated_entry_voltage = 1'h0;
    ext_valid = 1'h0;
    ext_req = '0;
  end
  task automatic pins(input logic lv, input logic hv);
    @(posedge clk);
    prog_entry_pin <= lv;
    elevated_entry_voltage <= hv;
  endtask
  // request held until taken; lines scrambled after release so no stale value helps
  task automatic access(input ppm_cmd_type c, input ppm_origin_type o, input logic [21:0] a,
                        input logic [7:0] d, output logic den, output logic [7:0] q);
    @(posedge clk);
    ext_valid <= 1'h1;
    ext_req <= '{origin: o, cmd: c, addr: a, wdata: d};
    do begin
      @(posedge clk);
    end while (ext_ready !== 1'h1);
    ext_valid <= 1'h0;
    ext_req <= ~ext_req;
    @(posedge clk);
    den = (ext_done === 1'h1) ? ext_denied : 1'hx;
    q = ext_rdata;
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
// ==========================================
// bench: apb master, programmer model, scenarios
module tb_top;
  import ppm_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e, den;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        prog_entry_pin, elevated_entry_voltage, ext_valid, ext_ready, ext_done, ext_denied;
  ppm_req_type ext_req;
  logic [7:0]  ext_rdata, q8;
  logic        prog_mode, prog_hv_session, prog_pin_dedicated, prog_pin_pullup_off, debug_enable;
  logic [1:0]  debug_pin_reserve;
  logic [4:0]  debug_stack_levels;
  logic [9:0]  debug_prog_bytes;
  logic [3:0]  debug_data_bytes;
  int          err_total, tests_run;
  ppm_guard ppm_guard_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .prog_entry_pin, .elevated_entry_voltage, .ext_valid, .ext_req, .ext_ready, .ext_done,
    .ext_denied, .ext_rdata, .prog_mode, .prog_hv_session, .prog_pin_dedicated, .prog_pin_pullup_off,
    .debug_enable, .debug_pin_reserve, .debug_stack_levels, .debug_prog_bytes, .debug_data_bytes);
  ppm_prog_model ppm_prog_model_i (.clk, .prog_entry_pin, .elevated_entry_voltage, .ext_valid,
    .ext_req, .ext_ready, .ext_done, .ext_denied, .ext_rdata);
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // no cycle count is assumed; only the watchdog ends a missing answer
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic ewr(input logic [21:0] a, input logic [7:0] d);
    ppm_prog_model_i.access(PPM_CMD_WRITE, PPM_ORIGIN_EXT, a, d, den, q8);
  endtask
  task automatic erd(input ppm_origin_type o, input logic [21:0] a);
    ppm_prog_model_i.access(PPM_CMD_READ, o, a, 8'h00, den, q8);
  endtask
  // pins pass two sync stages, so allow a few cycles for the mode change
  task automatic mode(input logic lv, input logic hv, input logic want);
    int n;
    n = 0;
    ppm_prog_model_i.pins(lv, hv);
    while (prog_mode !== want && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(prog_mode, want);
  endtask
  task automatic t_reset();
    apb(1'h0, 12'h000, 32'h0);
    chk(q, 32'h1f);
    chk({debug_enable, prog_pin_dedicated}, 2'h1);
    chk(prog_pin_pullup_off, 1'h1);
    apb(1'h0, 12'h010, 32'h0);
    chk(e, 1'h1);
  endtask
  task automatic t_lv();
    mode(1'h1, 1'h0, 1'h1);
    apb(1'h0, 12'h004, 32'h0);
    chk(q, 32'h15);
    ewr(22'h200003, 8'ha5);
    erd(PPM_ORIGIN_EXT, 22'h200003);
    chk(q8, 8'ha5);
    apb(1'h0, 12'h02c, 32'h0);
    chk(q, 32'ha5);
    ewr(22'h300000, 8'h0f);
    apb(1'h0, 12'h000, 32'h0);
    chk(q, 32'h1f);
    ewr(22'h3f0010, 8'h5a);
    chk(den, 1'h0);
    mode(1'h0, 1'h0, 1'h0);
  endtask
  task automatic t_hv();
    mode(1'h0, 1'h1, 1'h1);
    chk(prog_hv_session, 1'h1);
    ewr(22'h300000, 8'h0d);
    chk(prog_pin_dedicated, 1'h0);
    chk(prog_pin_pullup_off, 1'h0);
    ewr(22'h3f0010, 8'h77);
    chk(den, 1'h1);
    erd(PPM_ORIGIN_EXT, 22'h3f0010);
    chk({den, q8}, 9'h05a);
    ewr(22'h300000, 8'h0c);
    erd(PPM_ORIGIN_EXT, 22'h3f0010);
    chk(den, 1'h1);
    erd(PPM_ORIGIN_CPU, 22'h3f0010);
    chk({den, q8}, 9'h05a);
    apb(1'h1, 12'h008, 32'h10);
    apb(1'h1, 12'h00c, 32'h33);
    apb(1'h0, 12'h00c, 32'h0);
    chk(q, 32'h33);
    erd(PPM_ORIGIN_EXT, 22'h200003);
    chk({den, q8}, 9'h0a5);
    ewr(22'h300000, 8'h08);
    ewr(22'h300000, 8'h00);
    chk(den, 1'h1);
    apb(1'h1, 12'h000, 32'h0);
    chk(e, 1'h1);
    mode(1'h0, 1'h0, 1'h0);
  endtask
  task automatic t_lvp_off();
    ppm_prog_model_i.pins(1'h1, 1'h0);
    repeat (6) @(posedge clk);
    chk(prog_mode, 1'h0);
    chk(ext_ready, 1'h0);
    mode(1'h0, 1'h1, 1'h1);
    ppm_prog_model_i.access(PPM_CMD_BULK_ERASE, PPM_ORIGIN_EXT, 22'h0, 8'h00, den, q8);
    apb(1'h0, 12'h000, 32'h0);
    chk(q, 32'h1f);
    mode(1'h0, 1'h0, 1'h0);
  endtask
  task automatic t_cpu_cfg();
    apb(1'h1, 12'h000, 32'h0);
    apb(1'h0, 12'h000, 32'h0);
    chk(q, 32'h14);
    chk({debug_enable, debug_pin_reserve, debug_stack_levels, debug_prog_bytes, debug_data_bytes},
        {1'h1, 2'h3, 5'h02, 10'h200, 4'ha});
    apb(1'h1, 12'h000, 32'h1f);
    apb(1'h0, 12'h000, 32'h0);
    chk(q, 32'h14);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    err_total = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_lv();
    t_hv();
    t_lvp_off();
    t_cpu_cfg();
    summarize();
  end
  // cut a hang well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule
